// *** ics_pkg.sv ***
// package: constants for the serial channel switch target
package ics_pkg;
  localparam logic [6:0] ADDR_BASE = 7'h70;   // base target address
  localparam logic [7:0] CHAN_RESET = 8'h00;  // channel select after reset
  localparam int NUM_CHAN = 8;                // downstream channels
  localparam logic [3:0] BIT_LAST = 4'h7;     // last bit index of a byte
  localparam logic [3:0] BIT_ACK = 4'h8;      // bit index of the ack slot
  localparam logic [3:0] BIT_FIRST = 4'h0;    // first bit index
  localparam logic [3:0] BIT_PRE = 4'hF;      // before first address bit
  // serial engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,  // waiting for a start
    ST_ADDR = 5'b00010,  // shifting in the address byte
    ST_WDAT = 5'b00100,  // receiving register bytes
    ST_RDAT = 5'b01000,  // sending register bytes
    ST_SKIP = 5'b10000   // not addressed, wait for start
  } ics_state_t;
endpackage

// *** ics_switch_ctl.sv ***
// module: serial-bus target logic of the eight-channel switch
module ics_switch_ctl (
  input wire logic CLK,                 // system clock, 250 MHz
  input wire logic RST_B,               // async reset, active low
  input wire logic CE,                  // clock enable, freezes state
  input wire logic SCL_PIN,             // bus clock level from pin
  input wire logic SDA_PIN,             // bus data level from pin
  output logic SDA_DRV,                 // data drive value, always low
  output logic SDA_OE,                  // high while pulling data low
  input wire logic ADDR_STRAP_LOW,      // address strap bit 0
  input wire logic ADDR_STRAP_MID,      // address strap bit 1
  input wire logic ADDR_STRAP_HIGH,     // address strap bit 2
  output logic [7:0] CHAN_EN            // connected downstream channels
);
  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;  // reset release chain
  logic rst_n;             // released reset copy
  logic [1:0] scl_s_q;     // scl sync chain
  logic [1:0] sda_s_q;     // sda sync chain
  logic [2:0] strap_s0_q;  // strap sync first stage
  logic [2:0] strap_s1_q;  // strap sync second stage
  logic scl_d1_q;          // previous synced scl
  logic sda_d1_q;          // previous synced sda

  // release reset through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // two-flop synchronisers; only stage two is read by logic
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      strap_s0_q <= 3'h0;
      strap_s1_q <= 3'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else if (CE) begin
      scl_s_q <= {scl_s_q[0], SCL_PIN};
      sda_s_q <= {sda_s_q[0], SDA_PIN};
      strap_s0_q <= {ADDR_STRAP_HIGH, ADDR_STRAP_MID, ADDR_STRAP_LOW};
      strap_s1_q <= strap_s0_q;
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus event detection
  logic scl;      // synced scl
  logic sda;      // synced sda
  logic scl_rise; // sample point
  logic scl_fall; // drive change point
  logic start_ev; // start or repeated start
  logic stop_ev;  // stop condition
  assign scl = scl_s_q[1];
  assign sda = sda_s_q[1];
  assign scl_rise = scl && !scl_d1_q;
  assign scl_fall = !scl && scl_d1_q;
  assign start_ev = scl && scl_d1_q && sda_d1_q && !sda;
  assign stop_ev = scl && scl_d1_q && !sda_d1_q && sda;

  ////////////////////////////////////////////////////////////////////////
  // serial engine
  ics_pkg::ics_state_t st_q, st_d; // engine state
  logic [3:0] bit_q, bit_d;        // bit index in byte, 8 is ack
  logic [7:0] sh_q, sh_d;          // shift register
  logic [7:0] sel_q, sel_d;        // channel select register
  logic [7:0] con_q, con_d;        // connected channels
  logic oe_q, oe_d;                // data line pull-down
  logic mack_q, mack_d;            // controller acked last read byte
  logic [6:0] my_addr;             // own target address

  assign my_addr = ics_pkg::ADDR_BASE + {4'h0, strap_s1_q};

  // next-state logic for engine and registers
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    sel_d = sel_q;
    con_d = con_q;
    oe_d = oe_q;
    mack_d = mack_q;
    if (stop_ev) begin
      st_d = ics_pkg::ST_IDLE;
      oe_d = 1'b0;
      con_d = sel_q;
    end else if (start_ev) begin
      st_d = ics_pkg::ST_ADDR; // restart also lands here
      // the clock fall that ends the start is no bit: it wraps to zero
      bit_d = ics_pkg::BIT_PRE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      // sample: shift in data bits, read ack bit from controller
      if (bit_q <= ics_pkg::BIT_LAST) begin
        sh_d = {sh_q[6:0], sda};
      end else if (st_q == ics_pkg::ST_RDAT) begin
        mack_d = !sda;
      end
    end else if (scl_fall) begin
      case (st_q)
        ics_pkg::ST_ADDR: begin
          if (bit_q == ics_pkg::BIT_LAST) begin
            if (sh_q[7:1] == my_addr) begin
              oe_d = 1'b1;
              bit_d = ics_pkg::BIT_ACK;
            end else begin
              st_d = ics_pkg::ST_SKIP;
            end
          end else if (bit_q == ics_pkg::BIT_ACK) begin
            bit_d = ics_pkg::BIT_FIRST;
            if (sh_q[0]) begin
              st_d = ics_pkg::ST_RDAT;
              sh_d = sel_q;
              oe_d = !sel_q[7];
            end else begin
              st_d = ics_pkg::ST_WDAT;
              oe_d = 1'b0;
            end
          end else begin
            bit_d = bit_q + 4'h1;
          end
        end
        ics_pkg::ST_WDAT: begin
          if (bit_q == ics_pkg::BIT_LAST) begin
            sel_d = sh_q;
            oe_d = 1'b1;
            bit_d = ics_pkg::BIT_ACK;
          end else if (bit_q == ics_pkg::BIT_ACK) begin
            oe_d = 1'b0;
            bit_d = ics_pkg::BIT_FIRST;
          end else begin
            bit_d = bit_q + 4'h1;
          end
        end
        ics_pkg::ST_RDAT: begin
          if (bit_q == ics_pkg::BIT_LAST) begin
            oe_d = 1'b0; // release for controller ack
            bit_d = ics_pkg::BIT_ACK;
          end else if (bit_q == ics_pkg::BIT_ACK) begin
            bit_d = ics_pkg::BIT_FIRST;
            if (mack_q) begin
              sh_d = sel_q;
              oe_d = !sel_q[7];
            end else begin
              st_d = ics_pkg::ST_SKIP; // nack: release, wait stop
              oe_d = 1'b0;
            end
          end else begin
            bit_d = bit_q + 4'h1;
            // sh_q already moved left at the rise, next bit sits on top
            oe_d = !sh_q[7];
          end
        end
        ics_pkg::ST_IDLE, ics_pkg::ST_SKIP: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = ics_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // register the engine; reset clears all
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ics_pkg::ST_IDLE;
      bit_q <= ics_pkg::BIT_FIRST;
      sh_q <= 8'h00;
      sel_q <= ics_pkg::CHAN_RESET;
      con_q <= ics_pkg::CHAN_RESET;
      oe_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (CE) begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      sel_q <= sel_d;
      con_q <= con_d;
      oe_q <= oe_d;
      mack_q <= mack_d;
    end
  end

  assign SDA_DRV = 1'b0;  // open drain: only ever pulls low
  assign SDA_OE = oe_q;
  assign CHAN_EN = con_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_conn_only_at_stop;
    @(posedge CLK) disable iff (!rst_n)
      (CE && !stop_ev) |=> $stable(CHAN_EN);
  endproperty
  a_conn_only_at_stop: assert property (p_conn_only_at_stop)
    else $error("channel connection changed without stop");

  property p_stop_connects;
    @(posedge CLK) disable iff (!rst_n)
      (CE && stop_ev) |=> (CHAN_EN == $past(sel_q));
  endproperty
  a_stop_connects: assert property (p_stop_connects)
    else $error("stop did not connect selection");

  property p_write_loads;
    @(posedge CLK) disable iff (!rst_n)
      (CE && scl_fall && !stop_ev && !start_ev && st_q == ics_pkg::ST_WDAT
       && bit_q == ics_pkg::BIT_LAST) |=> (sel_q == $past(sh_q)) && SDA_OE;
  endproperty
  a_write_loads: assert property (p_write_loads)
    else $error("written byte not stored or not acked");

  property p_skip_silent;
    @(posedge CLK) disable iff (!rst_n)
      (st_q == ics_pkg::ST_SKIP) |-> !SDA_OE;
  endproperty
  a_skip_silent: assert property (p_skip_silent)
    else $error("drove bus while not addressed");

  property p_idle_silent;
    @(posedge CLK) disable iff (!rst_n)
      (st_q == ics_pkg::ST_IDLE) |-> !SDA_OE;
  endproperty
  a_idle_silent: assert property (p_idle_silent)
    else $error("drove bus while idle");

  property p_addr_ack;
    @(posedge CLK) disable iff (!rst_n)
      (CE && scl_fall && !stop_ev && !start_ev && st_q == ics_pkg::ST_ADDR
       && bit_q == ics_pkg::BIT_LAST && sh_q[7:1] == my_addr) |=> SDA_OE;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acked");

  property p_read_first;
    @(posedge CLK) disable iff (!rst_n)
      (CE && scl_fall && !stop_ev && !start_ev && st_q == ics_pkg::ST_ADDR
       && bit_q == ics_pkg::BIT_ACK && sh_q[0]) |=>
        (st_q == ics_pkg::ST_RDAT) && (SDA_OE == !sel_q[7]);
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("read did not start with msb");

  property p_strap_addr;
    @(posedge CLK) disable iff (!rst_n)
      (CE && scl_fall && !stop_ev && !start_ev && st_q == ics_pkg::ST_ADDR
       && bit_q == ics_pkg::BIT_LAST
       && sh_q[7:4] != ics_pkg::ADDR_BASE[6:3])
      |=> (st_q == ics_pkg::ST_SKIP);
  endproperty
  a_strap_addr: assert property (p_strap_addr)
    else $error("address outside strap range was accepted");

  c_write: cover property (@(posedge CLK) disable iff (!rst_n)
    st_q == ics_pkg::ST_WDAT && scl_fall && bit_q == ics_pkg::BIT_LAST);
  c_read: cover property (@(posedge CLK) disable iff (!rst_n)
    st_q == ics_pkg::ST_RDAT && scl_fall && bit_q == ics_pkg::BIT_ACK);
  c_skip: cover property (@(posedge CLK) disable iff (!rst_n)
    st_q == ics_pkg::ST_SKIP);
endmodule // ics_switch_ctl

// *** ics_bus_master.sv ***
// file: upstream bus controller model driving the switch target
module ics_bus_master (
  input wire logic clk,  // system clock, paces every bus phase
  input wire logic sda,  // resolved data wire, pulled up
  output logic scl,      // bus clock, idle high
  output logic sda_low   // high while the controller pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;
  // released bus at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // quarter of a 64 ns bus clock period
  task q4;
    repeat (4) @(posedge clk);
  endtask
  // start or repeated start: data falls while clock is high
  task start;
    sda_low <= 1'b0;
    q4;
    scl <= 1'b1;
    q4;
    sda_low <= 1'b1;
    q4;
    scl <= 1'b0;
    q4;
  endtask
  // one bit; data moves mid low phase, sampled mid high phase
  task bit_x(input logic b, output logic s);
    sda_low <= ~b;
    q4;
    scl <= 1'b1;
    q4;
    s = sda;
    q4;
    scl <= 1'b0;
    q4;
  endtask
  // byte msb first, then the ack slot; a = 1 releases the line
  task xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
             output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ack);
  endtask
  // stop right after the last ack slot, data rises while clock high
  task stop;
    sda_low <= 1'b1;
    q4;
    scl <= 1'b1;
    q4;
    sda_low <= 1'b0;
    q4;
  endtask
endmodule // ics_bus_master

// *** ics_switch_ctl_bench.sv ***
// file: self-checking bench for the channel switch target logic
module ics_switch_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, scl, m_low, dev_oe, ack; // bench-side nets
  logic [2:0] strap;       // address straps, static within transfers
  logic [7:0] chan_en, q;  // connected channels, last byte read
  logic [7:0] sel;         // expected select register
  int err_total, comparisons;
  wire sda = ~(m_low | dev_oe); // open drain with pull-up
  ics_switch_ctl ics_switch_ctl_inst (.CLK(clk), .RST_B(rst_b), .CE(1'b1),
    .SCL_PIN(scl), .SDA_PIN(sda), .SDA_DRV(), .SDA_OE(dev_oe),
    .ADDR_STRAP_LOW(strap[0]), .ADDR_STRAP_MID(strap[1]),
    .ADDR_STRAP_HIGH(strap[2]), .CHAN_EN(chan_en));
  ics_bus_master ics_bus_master_inst (.clk(clk), .sda(sda), .scl(scl),
    .sda_low(m_low));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  // compare tasks, one per result width
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  // write n bytes d, d+1..; hit says whether the address should ack
  task wr(input logic [6:0] a, input logic [7:0] d, input int n,
          input logic hit);
    logic [7:0] old;
    old = sel;
    ics_bus_master_inst.start;
    ics_bus_master_inst.xbyte({a, 1'b0}, 1'b1, q, ack);
    chk1("address ack", ~hit, ack);
    for (int k = 0; k < n && hit; k++) begin
      ics_bus_master_inst.xbyte(d + 8'(k), 1'b1, q, ack);
      chk1("data ack", 1'b0, ack);
      sel = d + 8'(k);
    end
    chk8("chan before stop", old, chan_en);
    ics_bus_master_inst.stop;
    repeat (8) @(posedge clk);
    chk8("chan after stop", sel, chan_en);
  endtask
  // read n bytes, acking all but the final one
  task rd(input logic [6:0] a, input int n);
    ics_bus_master_inst.start;
    ics_bus_master_inst.xbyte({a, 1'b1}, 1'b1, q, ack);
    chk1("read address ack", 1'b0, ack);
    for (int k = 1; k <= n; k++) begin
      ics_bus_master_inst.xbyte(8'hFF, k == n, q, ack);
      chk8("read data", sel, q);
    end
    ics_bus_master_inst.stop;
    repeat (8) @(posedge clk);
  endtask
  // verdict, the single exit of the run
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far beyond the ~6k cycles the tests need
  initial begin
    #200000;
    err_total++;
    $display("Error watchdog expected done seen timeout");
    final_report;
  end
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    strap = 3'h0;
    sel = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk8("chan at reset", 8'h00, chan_en);
    rd(ics_pkg::ADDR_BASE, 1);
    $display("test reset values done");
    // every strap value, each channel bit, plus a foreign address
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      repeat (4) @(posedge clk);
      wr(ics_pkg::ADDR_BASE + 7'(s), 8'h01 << s, 1, 1'b1);
      wr(ics_pkg::ADDR_BASE + 7'((s + 1) % 8), 8'hA5, 1, 1'b0);
    end
    wr(ics_pkg::ADDR_BASE ^ 7'h08, 8'h5A, 1, 1'b0);
    $display("test straps and channels done");
    wr(ics_pkg::ADDR_BASE + 7'h7, 8'h3C, 3, 1'b1);
    rd(ics_pkg::ADDR_BASE + 7'h7, 3);
    $display("test multi byte done");
    // reset in mid-transfer must clear channels and the engine
    ics_bus_master_inst.start;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk8("chan in reset", 8'h00, chan_en);
    rst_b <= 1'b1;
    sel = 8'h00;
    ics_bus_master_inst.stop;
    repeat (8) @(posedge clk);
    rd(ics_pkg::ADDR_BASE + 7'h7, 1);
    $display("test mid-run reset done");
    final_report;
  end
endmodule // ics_switch_ctl_bench
